/* verilog/sspc_consts.svh */
// register map, writable control mask, reset values and timing of the serial port
`ifndef SSPC_CONSTS_SVH
`define SSPC_CONSTS_SVH

`define SSPC_ADDR_W        12
`define SSPC_OFS_STATUS    12'h000
`define SSPC_OFS_RX        12'h004
`define SSPC_OFS_TX        12'h008
`define SSPC_OFS_DIV       12'h00C
`define SSPC_OFS_CTRL      12'h010

`define SSPC_CTRL_RESET    16'h0000
`define SSPC_CTRL_MASK     16'h1FEF
`define SSPC_DIV_RESET     8'h1B

// 20.48 MHz reference made from the 200 MHz clock: 20.48 / 200 = 64 / 625
`define SSPC_PCLK_KHZ      200000
`define SSPC_REF_KHZ       20480
`define SSPC_REF_NUM       64
`define SSPC_REF_DEN       625

`define SSPC_EDGES_PER_BYTE 16
`define SSPC_STALL_HALVES   2

`endif

/* verilog/sspc_pkg.sv */
// types shared by the serial port control blocks
package sspc_pkg;

	typedef struct packed {
		logic [2:0] rsv_hi;
		logic       cont;
		logic       loopback;
		logic       slv_out_en;
		logic       sel_out_en;
		logic       rx_overwrite;
		logic       udf_repeat;
		logic       tx_mode;
		logic       lsb_first;
		logic       rsv4;
		logic       cpol;
		logic       cpha;
		logic       master;
		logic       enable;
	} sspc_ctrl_t;

	typedef struct packed {
		logic [1:0] rsv;
		logic       rx_ovf;
		logic       rx_irq;
		logic       rx_full;
		logic       tx_udf;
		logic       tx_irq;
		logic       tx_full;
	} sspc_stat_t;

	// one pin as the module sees it: level out, enable active low
	typedef struct packed {
		logic o;
		logic oe_n;
	} sspc_pin_t;

	typedef enum logic [1:0] {
		SSPC_IDLE,
		SSPC_RUN,
		SSPC_STALL
	} sspc_mst_state_t;

endpackage

/* verilog/sspc_sync.sv */
// three-stage pin synchroniser with agreement filter
module sspc_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] q_q;

	assign q = q_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			q_q  <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					q_q[i] <= s3_q[i];
				end
			end
		end
	end
endmodule

/* verilog/sspc_baud.sv */
// half-period tick generator for the master serial clock
`include "sspc_consts.svh"
module sspc_baud #(
	parameter int NUM = `SSPC_REF_NUM,
	parameter int DEN = `SSPC_REF_DEN
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       run,
	input  wire logic [7:0] div,
	output logic            half_tick
);
	localparam logic [9:0] NUM_C = 10'(NUM);
	localparam logic [9:0] DEN_C = 10'(DEN);

	logic [9:0] acc_q;
	logic [8:0] cnt_q;
	wire  [9:0] acc_sum = acc_q + NUM_C;
	wire        ref_tick = acc_sum >= DEN_C;
	wire        cnt_end = cnt_q == {1'b0, div};

	// one half period lasts 1+div ticks of the reference
	assign half_tick = run && ref_tick && cnt_end;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= '0;
			cnt_q <= '0;
		end else if (!run) begin
			acc_q <= '0;
			cnt_q <= '0;
		end else begin
			acc_q <= ref_tick ? acc_sum - DEN_C : acc_sum;
			if (ref_tick) begin
				cnt_q <= cnt_end ? 9'h000 : cnt_q + 9'h001;
			end
		end
	end
endmodule

/* verilog/sspc_top.sv */
// serial port control: APB registers, master and slave byte engines
//
// Decided for this implementation: register access over APB and the address map.
`include "sspc_consts.svh"
module sspc_top (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [31:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    sclk_i,
	output sspc_pkg::sspc_pin_t          sclk_pin,
	input  wire logic                    mosi_i,
	output sspc_pkg::sspc_pin_t          mosi_pin,
	input  wire logic                    miso_i,
	output sspc_pkg::sspc_pin_t          miso_pin,
	input  wire logic                    sel_n_i,
	output sspc_pkg::sspc_pin_t          sel_n_pin,
	output logic                         irq
);
	sspc_pkg::sspc_ctrl_t      ctrl_q;
	sspc_pkg::sspc_stat_t      stat;
	sspc_pkg::sspc_mst_state_t mst_q;
	logic [7:0] div_q;
	logic [7:0] tx_q;
	logic       tx_full_q;
	logic [7:0] prev_q;
	logic       tx_udf_q;
	logic       tx_irq_q;
	logic [7:0] rx_q;
	logic       rx_full_q;
	logic       rx_ovf_q;
	logic       start_req_q;
	logic [7:0] tsh_q;
	logic [7:0] rsh_q;
	logic [3:0] rcnt_q;
	logic       dout_q;
	logic       sclk_q;
	logic       sel_n_q;
	logic [4:0] edge_q;
	logic       s_sclk_q;
	logic       s_sel_n_q;
	logic       s_act_q;

	// apb decode
	wire [11:0] ofs = paddr[11:0];
	wire        acc = psel && penable;
	wire        hit_stat = ofs == `SSPC_OFS_STATUS;
	wire        hit_rx = ofs == `SSPC_OFS_RX;
	wire        hit_tx = ofs == `SSPC_OFS_TX;
	wire        hit_div = ofs == `SSPC_OFS_DIV;
	wire        hit_ctrl = ofs == `SSPC_OFS_CTRL;
	wire        mapped = (paddr[31:12] == 20'h00000)
		&& (hit_stat || hit_rx || hit_tx || hit_div || hit_ctrl);
	wire        wr_tx = acc && pwrite && hit_tx && mapped;
	wire        wr_div = acc && pwrite && hit_div && mapped;
	wire        wr_ctrl = acc && pwrite && hit_ctrl && mapped;
	wire        rd_rx = acc && !pwrite && hit_rx && mapped;

	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	assign stat = '{rsv: 2'b00, rx_ovf: rx_ovf_q, rx_irq: rx_full_q || rx_ovf_q,
		rx_full: rx_full_q, tx_udf: tx_udf_q, tx_irq: tx_irq_q, tx_full: tx_full_q};
	assign prdata = !(acc && !pwrite && mapped) ? 32'h0000_0000
		: hit_stat ? {24'h000000, stat}
		: hit_rx ? {24'h000000, rx_q}
		: hit_div ? {24'h000000, div_q}
		: hit_ctrl ? {16'h0000, ctrl_q}
		: 32'h0000_0000;

	// mode terms
	wire en = ctrl_q.enable;
	wire is_mst = en && ctrl_q.master;
	wire is_slv = en && !ctrl_q.master;
	wire cpha = ctrl_q.cpha;
	wire cpol = ctrl_q.cpol;

	// pin synchronisers
	logic p_sclk;
	logic p_mosi;
	logic p_miso;
	logic p_sel_n;

	sspc_sync #(
		.W (4)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({sclk_i, mosi_i, miso_i, sel_n_i}),
		.q       ({p_sclk, p_mosi, p_miso, p_sel_n})
	);

	// master half-period ticks
	logic half_tick;

	sspc_baud u_baud (
		.pclk      (pclk),
		.presetn   (presetn),
		.run       (is_mst && mst_q != sspc_pkg::SSPC_IDLE),
		.div       (div_q),
		.half_tick (half_tick)
	);

	// master start conditions
	wire mst_go = ctrl_q.tx_mode ? tx_full_q : start_req_q;
	wire m_start = is_mst && mst_q == sspc_pkg::SSPC_IDLE && mst_go;
	wire m_edge = is_mst && mst_q == sspc_pkg::SSPC_RUN && half_tick;
	wire m_last = m_edge && edge_q == 5'(`SSPC_EDGES_PER_BYTE - 1);
	wire m_more = ctrl_q.cont && tx_full_q;
	wire m_stall_end = is_mst && mst_q == sspc_pkg::SSPC_STALL && half_tick
		&& edge_q == 5'(`SSPC_STALL_HALVES - 1);

	// slave edge detection on the filtered clock
	wire s_frame = is_slv && !p_sel_n;
	wire s_begin = is_slv && !p_sel_n && s_sel_n_q;
	wire s_edge = s_frame && s_act_q && (p_sclk != s_sclk_q);
	wire s_lead = s_edge && (s_sclk_q == cpol);

	// shared shift events: sample on one edge, launch on the other
	wire m_lead = m_edge && !edge_q[0];
	wire lead = is_mst ? m_lead : s_lead;
	wire any_edge = m_edge || s_edge;
	wire do_sample = any_edge && (lead != cpha);
	wire do_shift = any_edge && (lead == cpha);
	wire do_load = m_start || (m_last && m_more) || s_begin;
	wire miso_eff = ctrl_q.loopback ? dout_q : p_miso;
	wire din = is_mst ? miso_eff : p_mosi;
	wire rx_done = do_sample && rcnt_q == 4'h7;

	// next transmit byte, underflow substitute when empty
	wire [7:0] load_byte = tx_full_q ? tx_q : (ctrl_q.udf_repeat ? prev_q : 8'h00);
	wire load_udf = do_load && !tx_full_q;
	wire [7:0] shift_src = do_load ? load_byte : tsh_q;
	wire out_bit = ctrl_q.lsb_first ? shift_src[0] : shift_src[7];
	wire [7:0] shifted = ctrl_q.lsb_first ? {1'b0, shift_src[7:1]}
		: {shift_src[6:0], 1'b0};
	wire [7:0] rx_next = ctrl_q.lsb_first ? {din, rsh_q[7:1]} : {rsh_q[6:0], din};

	// control and divider registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `SSPC_CTRL_RESET;
			div_q <= `SSPC_DIV_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= pwdata[15:0] & `SSPC_CTRL_MASK;
			end
			if (wr_div) begin
				div_q <= pwdata[7:0];
			end
		end
	end

	// transmit holding and its flags; set wins over clear, except a write beats a non-underflow load on tx_irq
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_q <= 8'h00;
			tx_full_q <= 1'b0;
			prev_q <= 8'h00;
			tx_udf_q <= 1'b0;
			tx_irq_q <= 1'b0;
		end else begin
			if (wr_tx) begin
				tx_q <= pwdata[7:0];
			end
			tx_full_q <= wr_tx || (tx_full_q && !do_load);
			if (do_load) begin
				prev_q <= load_byte;
			end
			tx_udf_q <= load_udf || (tx_udf_q && !wr_tx);
			tx_irq_q <= (do_load && !wr_tx) || load_udf
				|| (tx_irq_q && !wr_tx && !(!en && mst_q == sspc_pkg::SSPC_IDLE));
		end
	end

	// receive holding, full and overflow; new data wins over the read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_q <= 8'h00;
			rx_full_q <= 1'b0;
			rx_ovf_q <= 1'b0;
			start_req_q <= 1'b0;
		end else begin
			if (rx_done && (!rx_full_q || rd_rx || ctrl_q.rx_overwrite)) begin
				rx_q <= rx_next;
			end
			rx_full_q <= rx_done || (rx_full_q && !rd_rx);
			rx_ovf_q <= (rx_done && rx_full_q && !rd_rx) || (rx_ovf_q && !rd_rx);
			start_req_q <= (rd_rx && is_mst && !ctrl_q.tx_mode)
				|| (start_req_q && !do_load && is_mst && !ctrl_q.tx_mode);
		end
	end

	// master sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mst_q <= sspc_pkg::SSPC_IDLE;
			edge_q <= 5'h00;
		end else if (!is_mst) begin
			mst_q <= sspc_pkg::SSPC_IDLE;
			edge_q <= 5'h00;
		end else begin
			unique case (mst_q)
				sspc_pkg::SSPC_IDLE: begin
					edge_q <= 5'h00;
					if (m_start) begin
						mst_q <= sspc_pkg::SSPC_RUN;
					end
				end
				sspc_pkg::SSPC_RUN: begin
					if (m_last) begin
						edge_q <= 5'h00;
						if (m_more) begin
							mst_q <= sspc_pkg::SSPC_RUN;
						end else if (ctrl_q.cont) begin
							mst_q <= sspc_pkg::SSPC_IDLE;
						end else begin
							mst_q <= sspc_pkg::SSPC_STALL;
						end
					end else if (m_edge) begin
						edge_q <= edge_q + 5'h01;
					end
				end
				sspc_pkg::SSPC_STALL: begin
					if (m_stall_end) begin
						mst_q <= sspc_pkg::SSPC_IDLE;
						edge_q <= 5'h00;
					end else if (half_tick) begin
						edge_q <= edge_q + 5'h01;
					end
				end
			endcase
		end
	end

	// serial clock and select of the master
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_q <= 1'b0;
			sel_n_q <= 1'b1;
		end else begin
			if (!is_mst || mst_q != sspc_pkg::SSPC_RUN || m_last) begin
				sclk_q <= cpol;
			end else if (m_edge) begin
				sclk_q <= ~sclk_q;
			end
			// released a cycle after the last edge so the final sample sees select low
			sel_n_q <= !((m_start || mst_q == sspc_pkg::SSPC_RUN) && is_mst);
		end
	end

	// slave framing state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_sclk_q <= 1'b0;
			s_sel_n_q <= 1'b1;
			s_act_q <= 1'b0;
		end else begin
			s_sclk_q <= p_sclk;
			s_sel_n_q <= p_sel_n || !is_slv;
			s_act_q <= s_frame;
		end
	end

	// shared shift registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tsh_q <= 8'h00;
			rsh_q <= 8'h00;
			rcnt_q <= 4'h0;
			dout_q <= 1'b0;
		end else begin
			if ((do_load && !cpha) || do_shift) begin
				dout_q <= out_bit;
				tsh_q <= shifted;
			end else if (do_load) begin
				tsh_q <= load_byte;
			end
			if (do_load) begin
				rcnt_q <= 4'h0;
			end else if (do_sample) begin
				rsh_q <= rx_next;
				rcnt_q <= rx_done ? 4'h0 : rcnt_q + 4'h1;
			end
		end
	end

	// pin drive, enables low while driving
	assign sclk_pin = '{o: sclk_q, oe_n: !is_mst};
	assign mosi_pin = '{o: dout_q, oe_n: !is_mst};
	assign miso_pin = '{o: dout_q, oe_n: !(is_slv && ctrl_q.slv_out_en && !p_sel_n)};
	assign sel_n_pin = '{o: sel_n_q, oe_n: !(is_mst && ctrl_q.sel_out_en)};

	// request line: empty transmit in write mode, full receive in read mode
	assign irq = ctrl_q.tx_mode ? tx_irq_q : (rx_full_q || rx_ovf_q);
endmodule

/* verif/sspc_slave_model.sv */
// behavioural spi slave facing the port in master mode
module sspc_slave_model (
	input wire logic	sclk,
	input wire logic	mosi,
	input wire logic	sel_n,
	input wire logic	cpol,
	input wire logic	cpha,
	input wire logic [7:0]	tx_byte,
	output logic	miso,
	output logic [7:0]	rx_byte,
	output int	frames
);
	timeunit 1ns;
	timeprecision 1ps;
	int	k;
	initial begin
		miso = 1'h0;
		rx_byte = 8'h00;
		frames = 0;
		k = 0;
	end
	always @(negedge sel_n) begin
		k = cpha ? 0 : 1;
		miso = cpha ? ~miso : tx_byte[7];
	end
	always @(sclk) begin
		if (!sel_n) begin
			if ((sclk != cpol) ^ cpha)
				rx_byte = {rx_byte[6:0], mosi};
			else if (k < 8) begin
				miso = tx_byte[7 - k];
				k++;
			end
		end
	end
	// released line shows no stale bit
	always @(posedge sel_n) begin
		miso = ~miso;
		frames++;
	end
endmodule

/* verif/sspc_asserts.sv */
// assertions over the serial port control ports
module sspc_asserts (
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [31:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic [31:0]	prdata,
	input sspc_pkg::sspc_pin_t	sclk_pin,
	input sspc_pkg::sspc_pin_t	mosi_pin,
	input sspc_pkg::sspc_pin_t	miso_pin,
	input sspc_pkg::sspc_pin_t	sel_n_pin,
	input wire logic	irq
);
	timeunit 1ns;
	timeprecision 1ps;
	sspc_pkg::sspc_ctrl_t	c;
	logic	acc, rd, wr_c, wr_t, rd_r, rd_c;
	logic [3:0]	quiet_q;
	assign acc = psel && penable;
	assign rd = acc && !pwrite;
	assign wr_c = acc && pwrite && paddr == 32'h10;
	assign wr_t = acc && pwrite && paddr == 32'h08;
	assign rd_r = rd && paddr == 32'h04;
	assign rd_c = rd && paddr == 32'h10;
	// shadow of the control word
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) c <= 16'h0000;
		else if (wr_c) c <= pwdata[15:0] & 16'h1FEF;
	// cycles with select high and control untouched
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) quiet_q <= 4'h0;
		else if (wr_c || !sel_n_pin.o) quiet_q <= 4'h0;
		else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ctrl_rsv:
		assert property (rd_c |-> prdata[15:13] == 3'h0 && !prdata[4])
		else $error("reserved bits read set");
	a_slv_gate:
		assert property (!miso_pin.oe_n && $stable(c) |-> c.enable && !c.master && c.slv_out_en)
		else $error("miso driven while gated");
	a_sel_gate:
		assert property (!sel_n_pin.oe_n && $stable(c) |-> c.enable && c.master && c.sel_out_en)
		else $error("select driven while gated");
	a_off_free:
		assert property (!c.enable [*3] |-> sclk_pin.oe_n && mosi_pin.oe_n && miso_pin.oe_n
			&& sel_n_pin.oe_n)
		else $error("pin driven while off");
	a_sclk_idle:
		assert property (quiet_q == 4'hF && c.enable && c.master |-> sclk_pin.o == c.cpol)
		else $error("clock idle level wrong");
	a_stall_gap:
		assert property ($rose(sel_n_pin.o) && c.enable && c.master && !c.cont
			|=> sel_n_pin.o [*8])
		else $error("select gap too short");
	a_half_min:
		assert property ($changed(sclk_pin.o) && !sel_n_pin.o |=> $stable(sclk_pin.o) [*8])
		else $error("clock half too short");
	a_tx_start:
		assert property (wr_t && c.tx_mode && c.master && c.enable |-> ##[1:1000] !sel_n_pin.o)
		else $error("tx write started nothing");
	a_rx_clear:
		assert property (rd_r && !c.tx_mode |=> !irq)
		else $error("rx read left flags");
	cover property ($rose(sel_n_pin.o) && c.cont);
	cover property (rd_r && !c.tx_mode && c.master);
	cover property (!miso_pin.oe_n);
endmodule
bind sspc_top sspc_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .sclk_pin, .mosi_pin, .miso_pin, .sel_n_pin, .irq);

/* verif/tb_spi_control_config.sv */
// self-checking bench of the serial port control block
module tb_spi_control_config;
	timeunit 1ns;
	timeprecision 1ps;
	logic	pclk = 1'h0;
	logic	presetn = 1'h0;
	logic	psel = 1'h0;
	logic	penable = 1'h0;
	logic	pwrite = 1'h0;
	logic [31:0]	paddr = 32'h0;
	logic [31:0]	pwdata = 32'h0;
	logic [31:0]	prdata, q;
	logic	pready, pslverr, irq, e;
	logic	sclk_w, mosi_w, miso_w, sel_w, s_miso;
	logic	tb_sel_n = 1'h1;
	logic	cpol = 1'h0;
	logic	cpha = 1'h0;
	logic [7:0]	s_tx = 8'h00;
	logic [7:0]	s_rx, d;
	int	frames, n;
	int	n_fail = 0;
	int	n_tests = 0;
	int	cyc = 0;
	sspc_pkg::sspc_pin_t	sclk_pin, mosi_pin, miso_pin, sel_n_pin;
	always #2.5 pclk = ~pclk;
	// released lines: clock and mosi pulled low, miso from the slave model, select from tb_sel_n
	assign sclk_w = sclk_pin.oe_n ? 1'h0 : sclk_pin.o;
	assign mosi_w = mosi_pin.oe_n ? 1'h0 : mosi_pin.o;
	assign miso_w = miso_pin.oe_n ? s_miso : miso_pin.o;
	assign sel_w = sel_n_pin.oe_n ? tb_sel_n : sel_n_pin.o;
	sspc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .sclk_i(sclk_w), .sclk_pin, .mosi_i(mosi_w), .mosi_pin,
		.miso_i(miso_w), .miso_pin, .sel_n_i(sel_w), .sel_n_pin, .irq);
	sspc_slave_model SLV (.sclk(sclk_w), .mosi(mosi_w), .sel_n(sel_w), .cpol, .cpha,
		.tx_byte(s_tx), .miso(s_miso), .rx_byte(s_rx), .frames);
	task automatic stop_test;
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_tests++;
		if (got !== ex) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, ex, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {20'h00000, a};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic set_ctl(input logic [31:0] v);
		apb(1'h1, 12'h010, v);
		cpol = v[3];
		cpha = v[2];
	endtask
	task automatic wait_fr(input int m);
		int k;
		k = 0;
		while (frames < m && k < 5000) begin
			@(posedge pclk);
			k++;
		end
		repeat (4) @(posedge pclk);
	endtask
	function automatic logic [7:0] rev(input logic [7:0] v);
		return {<<{v}};
	endfunction
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail++;
			stop_test();
		end
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		apb(1'h0, 12'h010, 32'h0);
		chk("ctrl rst", 32'h0, q);
		apb(1'h0, 12'h00C, 32'h0);
		chk("div rst", 32'h1B, q);
		apb(1'h1, 12'h010, 32'hE010);
		apb(1'h0, 12'h010, 32'h0);
		chk("ctrl rsv", 32'h0, q);
		apb(1'h0, 12'h014, 32'h0);
		chk("unmapped", 32'h1, {31'h0, e});
		apb(1'h1, 12'h00C, 32'h0);
		for (int i = 0; i < 4; i++) begin
			s_tx = 8'h3C + 8'(i);
			d = 8'hA5 ^ 8'(i);
			set_ctl(32'h0243 | 32'(i) << 2 | 32'(i & 1) << 5);
			apb(1'h1, 12'h008, {24'h0, d});
			wait_fr(frames + 1);
			chk("slave rx", {24'h0, i[0] ? rev(d) : d}, {24'h0, s_rx});
			chk("irq empty", 32'h1, {31'h0, irq});
			apb(1'h0, 12'h004, 32'h0);
			chk("rx data", {24'h0, i[0] ? rev(s_tx) : s_tx}, q);
			chk("sclk idle", {31'h0, i[1]}, {31'h0, sclk_pin.o});
		end
		set_ctl(32'h0283);
		apb(1'h0, 12'h004, 32'h0);
		wait_fr(frames + 1);
		chk("udf repeat", {24'h0, d}, {24'h0, s_rx});
		chk("irq full", 32'h1, {31'h0, irq});
		set_ctl(32'h0203);
		apb(1'h0, 12'h004, 32'h0);
		wait_fr(frames + 1);
		chk("udf zero", 32'h0, {24'h0, s_rx});
		apb(1'h0, 12'h000, 32'h0);
		chk("udf flag", 32'h1, {31'h0, q[2]});
		set_ctl(32'h0243);
		apb(1'h0, 12'h004, 32'h0);
		for (int i = 0; i < 2; i++) begin
			set_ctl(32'h0243 | 32'(i) << 8);
			s_tx = 8'h11;
			apb(1'h1, 12'h008, 32'h1);
			wait_fr(frames + 1);
			s_tx = 8'h22;
			apb(1'h1, 12'h008, 32'h2);
			wait_fr(frames + 1);
			apb(1'h0, 12'h000, 32'h0);
			chk("ovf flag", 32'h1, {31'h0, q[5]});
			apb(1'h0, 12'h004, 32'h0);
			chk("ovf data", i ? 32'h22 : 32'h11, q);
			apb(1'h0, 12'h000, 32'h0);
			chk("ovf clr", 32'h0, {29'h0, q[5:3]});
		end
		for (int i = 0; i < 2; i++) begin
			n = frames;
			set_ctl(i ? 32'h0243 : 32'h1243);
			apb(1'h1, 12'h008, 32'h5);
			apb(1'h1, 12'h008, 32'h6);
			wait_fr(n + 2);
			chk("frames", 32'(n + 1 + i), 32'(frames));
			chk("last byte", 32'h6, {24'h0, s_rx});
			apb(1'h0, 12'h004, 32'h0);
		end
		set_ctl(32'h0A43);
		s_tx = 8'h00;
		apb(1'h1, 12'h008, 32'h96);
		wait_fr(frames + 1);
		apb(1'h0, 12'h004, 32'h0);
		chk("loopback", 32'h96, q);
		set_ctl(32'h0043);
		repeat (4) @(posedge pclk);
		chk("sel oe", 32'h1, {31'h0, sel_n_pin.oe_n});
		set_ctl(32'h0401);
		tb_sel_n <= 1'h0;
		repeat (8) @(posedge pclk);
		chk("miso oe on", 32'h0, {31'h0, miso_pin.oe_n});
		set_ctl(32'h0001);
		repeat (4) @(posedge pclk);
		chk("miso oe off", 32'h1, {31'h0, miso_pin.oe_n});
		tb_sel_n <= 1'h1;
		set_ctl(32'h0000);
		repeat (4) @(posedge pclk);
		chk("pins off", 32'hF, {28'h0, sclk_pin.oe_n, mosi_pin.oe_n, miso_pin.oe_n,
			sel_n_pin.oe_n});
		stop_test();
	end
endmodule
